// File: rtl/sensor_diag_pkg.sv
package sensor_diag_pkg;

    // Sample timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 8_000;
    localparam int SAMPLE_CYCLES_DEF = CLK_HZ / SAMPLE_HZ;

    // Field component indices
    localparam int COMP_X = 0;
    localparam int COMP_Y = 1;
    localparam int COMP_Z = 2;

    // Value ranges and codes
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] CODE_MAX = 16'h7FFF;
    localparam logic [15:0] OFFSET_SEL_ON = 16'h7FFF;
    localparam logic [15:0] OFFSET_SEL_OFF = 16'h0000;
    localparam logic [15:0] TEMP_TYP_LOW = 16'h0064;
    localparam logic [15:0] TEMP_TYP_HIGH = 16'h2EE0;

    // Amplitude scale 205/128, close to 1.6
    localparam logic [23:0] AMP_GAIN_NUM = 24'h0000CD;
    localparam int AMP_GAIN_SHIFT = 7;
    localparam int SQRT_STEPS = 16;

    // Fault flag bit positions
    localparam int DIAG_SUPPLY_LOW = 12;
    localparam int DIAG_ADC_STUCK = 11;
    localparam int DIAG_CLAMP_HIGH = 9;
    localparam int DIAG_CLAMP_LOW = 8;
    localparam int DIAG_CLIP_A = 7;
    localparam int DIAG_CLIP_B = 6;
    localparam int DIAG_DSP_TEST = 5;
    localparam int DIAG_NVM_TEST = 4;
    localparam int DIAG_ROM_PARITY = 3;
    localparam int DIAG_TEMP_FAIL = 2;
    localparam int DIAG_FIELD_HIGH = 1;
    localparam int DIAG_FIELD_LOW = 0;

    typedef enum logic {
        ST_IDLE,
        ST_CALC
    } calc_state_t;

endpackage

// File: rtl/field_root.sv
`timescale 1ns/1ns
module field_root
    import sensor_diag_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [31:0] radicand,
    // Result
    output logic [15:0] root,
    output logic done
);
    logic [31:0] rad_reg, rad_next;
    logic [17:0] rem_reg, rem_next;
    logic [15:0] root_reg, root_next;
    logic [4:0] step_reg, step_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [17:0] rem_sh, trial;
    logic fits, last_step;

    // One result bit per step, remainder kept against the trial divisor
    assign rem_sh = {rem_reg[15:0], rad_reg[31:30]};
    assign trial = {root_reg, 2'b01};
    assign fits = rem_sh >= trial;
    assign last_step = step_reg == 5'(SQRT_STEPS - 1);

    always_comb begin
        rad_next = rad_reg;
        rem_next = rem_reg;
        root_next = root_reg;
        step_next = step_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start) begin
            rad_next = radicand;
            rem_next = '0;
            root_next = '0;
            step_next = '0;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            rad_next = {rad_reg[29:0], 2'b00};
            rem_next = fits ? 18'(rem_sh - trial) : rem_sh;
            root_next = {root_reg[14:0], fits};
            step_next = 5'(step_reg + 5'h01);
            busy_next = !last_step;
            done_next = last_step;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rad_reg <= '0;
            rem_reg <= '0;
            root_reg <= '0;
            step_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            rad_reg <= rad_next;
            rem_reg <= rem_next;
            root_reg <= root_next;
            step_reg <= step_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign root = root_reg;
    assign done = done_reg;

endmodule // field_root

// File: rtl/position_sensor_readout_diag.sv
// Function
// - Temperature 16-bit, codes 0 to 32767
// - Temperature calibrated, typ 100 to 12000
// - Compensated fields signed 16-bit per channel
// - Corrected inputs held, feed amplitude calculation
// - Position 16-bit, codes 0 to 32767
// - Output code 16-bit, codes 0 to 32767
// - Both selects zero: amplitude 1.6 root-sum-square
// - Either select 32767: amplitude sum of magnitudes
// - Test results reported in 16-bit fault word
// - Bit 12: internal supply too low
// - Bit 11: converter signal stuck
// - Bits 9/8: output high/low clamp reached
// - Bits 7/6: converter clipping channel a/b
// - Bit 5: signal processor test fails
// - Bit 4: nonvolatile memory test fails
// - Bit 3: program memory parity fails
// - Bit 2: temperature sensor invalid
// - Bits 1/0: field above/below thresholds
// - Measurement registers read-only from outside
// - Two channels, components fixed by variant
// - Measurements update at 8 kHz
// - Field outside window forces high clamp
// - High threshold signed 16-bit configuration
`timescale 1ns/1ns
module position_sensor_readout_diag
    import sensor_diag_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF,
    parameter int CH_A_COMPONENT = COMP_X,
    parameter int CH_B_COMPONENT = COMP_Y,
    parameter logic signed [15:0] TEMP_TRIM = 16'sh0000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Front-end samples
    input wire logic signed [15:0] field_x,
    input wire logic signed [15:0] field_y,
    input wire logic signed [15:0] field_z,
    input wire logic [15:0] temp_raw,
    input wire logic signed [15:0] corrected_src_a,
    input wire logic signed [15:0] corrected_src_b,
    input wire logic [15:0] position_src,
    input wire logic [15:0] code_src,
    // Nonvolatile configuration
    input wire logic [15:0] offset_select_a,
    input wire logic [15:0] offset_select_b,
    input wire logic signed [15:0] field_high_threshold,
    input wire logic signed [15:0] field_low_threshold,
    input wire logic [15:0] clamp_high_level,
    input wire logic [15:0] clamp_low_level,
    // Monitors
    input wire logic supply_low,
    input wire logic adc_stuck,
    input wire logic clip_a,
    input wire logic clip_b,
    input wire logic dsp_test_fail,
    input wire logic nvm_test_fail,
    input wire logic rom_parity_fail,
    input wire logic temp_invalid,
    // Measurement registers
    output logic [15:0] junction_temperature,
    output logic signed [15:0] compensated_field_a,
    output logic signed [15:0] compensated_field_b,
    output logic signed [15:0] corrected_input_a,
    output logic signed [15:0] corrected_input_b,
    output logic [15:0] position_result,
    output logic [15:0] output_code,
    output logic [15:0] field_amplitude,
    output logic [15:0] fault_flags,
    output logic force_high_clamp
);
    localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);
    localparam int CH_SEL [2] = '{CH_A_COMPONENT, CH_B_COMPONENT};

    function automatic logic [15:0] sat15(input logic [15:0] v);
        return v[15] ? CODE_MAX : v;
    endfunction

    calc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic tick, publish, start_reg;
    logic [15:0] sq_root;
    logic sq_done;

    // Sample snapshot
    logic signed [15:0] cap_comp [2];
    logic signed [15:0] cap_corr [2];
    logic [15:0] cap_temp, cap_pos, cap_code;
    logic [15:0] cap_clamp_hi, cap_clamp_lo;
    logic signed [15:0] cap_hi_thr, cap_lo_thr;
    logic cap_sum_mode;
    logic [7:0] cap_mon;

    // Per-channel derived values
    logic signed [15:0] field_all [3];
    logic signed [15:0] comp_sel [2];
    logic [16:0] abs_val [2];
    logic [31:0] sq_val [2];

    logic [31:0] radicand;
    logic [23:0] amp_prod;
    logic [16:0] amp_root17, amp_sum17, amp17;
    logic [15:0] amp_next;
    logic field_high, field_low, field_out;
    logic signed [17:0] temp_sum;
    logic [15:0] temp_next, code_lim, code_next;
    logic [15:0] fault_next;
    logic sum_mode;

    // Sample rate divider
    assign tick = cnt_reg == CNT_W'(SAMPLE_CYCLES - 1);
    assign cnt_next = tick ? '0 : CNT_W'(cnt_reg + 1'b1);
    assign publish = (state_reg == ST_CALC) && sq_done;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (tick) state_next = ST_CALC;
            ST_CALC: if (sq_done) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= '0;
            state_reg <= ST_IDLE;
            start_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            state_reg <= state_next;
            start_reg <= (state_reg == ST_IDLE) && tick;
        end
    end

    // Channel mapping and magnitudes
    assign field_all[COMP_X] = field_x;
    assign field_all[COMP_Y] = field_y;
    assign field_all[COMP_Z] = field_z;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign comp_sel[i] = field_all[CH_SEL[i]];
        assign abs_val[i] = cap_corr[i][15] ? 17'(-{cap_corr[i][15], cap_corr[i]})
                                            : {1'b0, cap_corr[i]};
        assign sq_val[i] = unsigned'(32'(cap_corr[i] * cap_corr[i]));
    end

    // Amplitude selection by offset select words
    assign sum_mode = (offset_select_a == OFFSET_SEL_ON) || (offset_select_b == OFFSET_SEL_ON);
    assign radicand = sq_val[0] + sq_val[1];
    assign amp_prod = {8'h00, sq_root} * AMP_GAIN_NUM;
    assign amp_root17 = 17'(amp_prod >> AMP_GAIN_SHIFT);
    assign amp_sum17 = abs_val[0] + abs_val[1];
    assign amp17 = cap_sum_mode ? amp_sum17 : amp_root17;
    assign amp_next = (amp17 > {1'b0, CODE_MAX}) ? CODE_MAX : amp17[15:0];

    // Field window against signed thresholds
    assign field_high = $signed({1'b0, amp_next}) > $signed({cap_hi_thr[15], cap_hi_thr});
    assign field_low = $signed({1'b0, amp_next}) < $signed({cap_lo_thr[15], cap_lo_thr});
    assign field_out = field_high || field_low;

    // Temperature trim and range limit
    assign temp_sum = $signed({2'b00, cap_temp}) + $signed({{2{TEMP_TRIM[15]}}, TEMP_TRIM});
    assign temp_next = temp_sum[17] ? REG_RESET
                     : (temp_sum > $signed({2'b00, CODE_MAX})) ? CODE_MAX
                     : temp_sum[15:0];

    // Output code limited, clamped, forced high outside window
    assign code_lim = sat15(cap_code);
    assign code_next = field_out ? cap_clamp_hi
                     : (code_lim >= cap_clamp_hi) ? cap_clamp_hi
                     : (code_lim <= cap_clamp_lo) ? cap_clamp_lo
                     : code_lim;

    always_comb begin
        fault_next = REG_RESET;
        fault_next[DIAG_SUPPLY_LOW] = cap_mon[7];
        fault_next[DIAG_ADC_STUCK] = cap_mon[6];
        fault_next[DIAG_CLAMP_HIGH] = code_next >= cap_clamp_hi;
        fault_next[DIAG_CLAMP_LOW] = code_next <= cap_clamp_lo;
        fault_next[DIAG_CLIP_A] = cap_mon[5];
        fault_next[DIAG_CLIP_B] = cap_mon[4];
        fault_next[DIAG_DSP_TEST] = cap_mon[3];
        fault_next[DIAG_NVM_TEST] = cap_mon[2];
        fault_next[DIAG_ROM_PARITY] = cap_mon[1];
        fault_next[DIAG_TEMP_FAIL] = cap_mon[0];
        fault_next[DIAG_FIELD_HIGH] = field_high;
        fault_next[DIAG_FIELD_LOW] = field_low;
    end

    // Snapshot of one sample, configuration taken with it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cap_comp <= '{REG_RESET, REG_RESET};
            cap_corr <= '{REG_RESET, REG_RESET};
            cap_temp <= REG_RESET;
            cap_pos <= REG_RESET;
            cap_code <= REG_RESET;
            cap_clamp_hi <= CODE_MAX;
            cap_clamp_lo <= REG_RESET;
            cap_hi_thr <= CODE_MAX;
            cap_lo_thr <= REG_RESET;
            cap_sum_mode <= 1'b0;
            cap_mon <= '0;
        end else if ((state_reg == ST_IDLE) && tick) begin
            cap_comp <= comp_sel;
            cap_corr <= '{corrected_src_a, corrected_src_b};
            cap_temp <= temp_raw;
            cap_pos <= position_src;
            cap_code <= code_src;
            cap_clamp_hi <= sat15(clamp_high_level);
            cap_clamp_lo <= sat15(clamp_low_level);
            cap_hi_thr <= field_high_threshold;
            cap_lo_thr <= field_low_threshold;
            cap_sum_mode <= sum_mode;
            cap_mon <= {supply_low, adc_stuck, clip_a, clip_b,
                        dsp_test_fail, nvm_test_fail, rom_parity_fail, temp_invalid};
        end
    end

    field_root u_root (
        .core_clk(core_clk),
        .rst(rst),
        .start(start_reg),
        .radicand(radicand),
        .root(sq_root),
        .done(sq_done)
    );

    // Published registers, only written here; no path from outside
    always_ff @(posedge core_clk) begin
        if (rst) begin
            junction_temperature <= REG_RESET;
            compensated_field_a <= REG_RESET;
            compensated_field_b <= REG_RESET;
            corrected_input_a <= REG_RESET;
            corrected_input_b <= REG_RESET;
            position_result <= REG_RESET;
            output_code <= REG_RESET;
            field_amplitude <= REG_RESET;
            fault_flags <= REG_RESET;
            force_high_clamp <= 1'b0;
        end else if (publish) begin
            junction_temperature <= temp_next;
            compensated_field_a <= cap_comp[0];
            compensated_field_b <= cap_comp[1];
            corrected_input_a <= cap_corr[0];
            corrected_input_b <= cap_corr[1];
            position_result <= sat15(cap_pos);
            output_code <= code_next;
            field_amplitude <= amp_next;
            fault_flags <= fault_next;
            force_high_clamp <= field_out;
        end
    end

    // Checks
    int gap_reg;
    logic seen_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            gap_reg <= 0;
            seen_reg <= 1'b0;
        end else if (publish) begin
            gap_reg <= 0;
            seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_TEMP_RANGE: assert property (
        !junction_temperature[15] && !position_result[15] && !output_code[15])
        else $error("measurement code above 32767");

    AST_TEMP_TRIM: assert property (
        publish && !temp_sum[17] && (temp_sum <= $signed({2'b00, CODE_MAX}))
        |=> junction_temperature == 16'($past(temp_sum)))
        else $error("temperature not equal to trimmed raw value");

    AST_CORR_HELD: assert property (
        publish |=> corrected_input_a == $past(cap_corr[0])
                 && corrected_input_b == $past(cap_corr[1]))
        else $error("corrected inputs not published from snapshot");

    AST_POS_SAT: assert property (
        publish && cap_pos[15] |=> position_result == CODE_MAX)
        else $error("position above range not limited");

    AST_AMP_ROOT: assert property (
        publish && !cap_sum_mode && amp_root17 <= {1'b0, CODE_MAX}
        |=> field_amplitude == 16'($past(amp_root17)))
        else $error("root amplitude mismatch");

    AST_AMP_SUM: assert property (
        (state_reg == ST_IDLE) && tick && sum_mode |-> ##18 publish
        ##1 field_amplitude == ((amp_sum17 > {1'b0, CODE_MAX}) ? CODE_MAX : amp_sum17[15:0]))
        else $error("sum amplitude mismatch");

    AST_SUPPLY_FLAG: assert property (
        (state_reg == ST_IDLE) && tick && supply_low |-> ##19 fault_flags[DIAG_SUPPLY_LOW])
        else $error("supply flag not reported");

    AST_CLIP_FLAGS: assert property (
        publish |=> fault_flags[DIAG_CLIP_A] == $past(cap_mon[5])
                 && fault_flags[DIAG_CLIP_B] == $past(cap_mon[4]))
        else $error("clip flags not reported");

    AST_FIELD_FLAGS: assert property (
        publish |=> fault_flags[DIAG_FIELD_HIGH] == $past(field_high)
                 && fault_flags[DIAG_FIELD_LOW] == $past(field_low)
                 && fault_flags[15:13] == 3'h0)
        else $error("field flags wrong");

    AST_FORCE_CLAMP: assert property (
        publish && field_out
        |=> force_high_clamp && output_code == $past(cap_clamp_hi)
            && fault_flags[DIAG_CLAMP_HIGH])
        else $error("out-of-window field did not force high clamp");

    AST_SAMPLE_PERIOD: assert property (
        publish && seen_reg |-> gap_reg == SAMPLE_CYCLES - 1)
        else $error("sample period wrong");

    AST_ROOT_LATENCY: assert property (
        start_reg |-> ##[17:17] sq_done)
        else $error("root result late");

    AST_ATOMIC: assert property (
        !publish |=> $stable(output_code) && $stable(fault_flags)
                  && $stable(field_amplitude) && $stable(junction_temperature))
        else $error("register changed between samples");

    COV_SUM_MODE: cover property (publish && cap_sum_mode);
    COV_ROOT_MODE: cover property (publish && !cap_sum_mode && !field_out);
    COV_FORCE: cover property (publish && field_out);
    COV_TEMP_TYP: cover property (publish ##1 junction_temperature >= TEMP_TYP_LOW
                                  && junction_temperature <= TEMP_TYP_HIGH);

endmodule // position_sensor_readout_diag

// File: test/monitor_source_model.sv
`timescale 1ns/1ns
module monitor_source_model (
    // Clock
    input wire logic core_clk,
    // Requested fault pattern
    input wire logic [7:0] pattern,
    // Monitor levels
    output logic supply_low,
    output logic adc_stuck,
    output logic clip_a,
    output logic clip_b,
    output logic dsp_test_fail,
    output logic nvm_test_fail,
    output logic rom_parity_fail,
    output logic temp_invalid
);
    initial begin
        {supply_low, adc_stuck, clip_a, clip_b} = 4'h0;
        {dsp_test_fail, nvm_test_fail, rom_parity_fail, temp_invalid} = 4'h0;
    end

    // Monitors settle one cycle after the request, well ahead of the next snapshot
    always @(posedge core_clk) begin
        {supply_low, adc_stuck, clip_a, clip_b} <= pattern[7:4];
        {dsp_test_fail, nvm_test_fail, rom_parity_fail, temp_invalid} <= pattern[3:0];
    end
endmodule // monitor_source_model

// File: test/position_sensor_readout_diag_bench.sv
`timescale 1ns/1ns
module position_sensor_readout_diag_bench;
    import sensor_diag_pkg::*;
    localparam int SC = 40;
    localparam int NV = 24;
    typedef struct {
        logic [15:0] temp, fa, fb, ia, ib, pos, code, amp, flags;
        logic force_hi;
    } exp_t;
    exp_t q[$];
    int fails = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'hB323;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic signed [15:0] field_x = 16'h0000, field_y = 16'h0000, field_z = 16'h0000;
    logic signed [15:0] corrected_src_a = 16'h0000, corrected_src_b = 16'h0000;
    logic signed [15:0] field_high_threshold = 16'h7FFF, field_low_threshold = 16'h0000;
    logic [15:0] temp_raw = 16'h0000, position_src = 16'h0000, code_src = 16'h0000;
    logic [15:0] offset_select_a = 16'h0000, offset_select_b = 16'h0000;
    logic [15:0] clamp_high_level = 16'h7FFF, clamp_low_level = 16'h0000;
    logic [7:0] mon_pattern = 8'h00;
    wire logic supply_low, adc_stuck, clip_a, clip_b;
    wire logic dsp_test_fail, nvm_test_fail, rom_parity_fail, temp_invalid;
    logic [15:0] junction_temperature, position_result, output_code, field_amplitude;
    logic [15:0] fault_flags;
    logic signed [15:0] compensated_field_a, compensated_field_b;
    logic signed [15:0] corrected_input_a, corrected_input_b;
    logic force_high_clamp;

    always #5 core_clk = ~core_clk;

    monitor_source_model monitor_source_model_inst (
        .core_clk(core_clk), .pattern(mon_pattern), .supply_low(supply_low),
        .adc_stuck(adc_stuck), .clip_a(clip_a), .clip_b(clip_b),
        .dsp_test_fail(dsp_test_fail), .nvm_test_fail(nvm_test_fail),
        .rom_parity_fail(rom_parity_fail), .temp_invalid(temp_invalid)
    );

    position_sensor_readout_diag #(
        .SAMPLE_CYCLES(SC), .CH_A_COMPONENT(COMP_X), .CH_B_COMPONENT(COMP_Z),
        .TEMP_TRIM(16'sh0000)
    ) position_sensor_readout_diag_inst (
        .core_clk(core_clk), .rst(rst), .field_x(field_x), .field_y(field_y),
        .field_z(field_z), .temp_raw(temp_raw), .corrected_src_a(corrected_src_a),
        .corrected_src_b(corrected_src_b), .position_src(position_src),
        .code_src(code_src), .offset_select_a(offset_select_a),
        .offset_select_b(offset_select_b), .field_high_threshold(field_high_threshold),
        .field_low_threshold(field_low_threshold), .clamp_high_level(clamp_high_level),
        .clamp_low_level(clamp_low_level), .supply_low(supply_low), .adc_stuck(adc_stuck),
        .clip_a(clip_a), .clip_b(clip_b), .dsp_test_fail(dsp_test_fail),
        .nvm_test_fail(nvm_test_fail), .rom_parity_fail(rom_parity_fail),
        .temp_invalid(temp_invalid), .junction_temperature(junction_temperature),
        .compensated_field_a(compensated_field_a), .compensated_field_b(compensated_field_b),
        .corrected_input_a(corrected_input_a), .corrected_input_b(corrected_input_b),
        .position_result(position_result), .output_code(output_code),
        .field_amplitude(field_amplitude), .fault_flags(fault_flags),
        .force_high_clamp(force_high_clamp)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [15:0] r;
        logic [31:0] t;
        r = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            t = 32'(r | (16'h0001 << i));
            if (t * t <= v) r = t[15:0];
        end
        return r;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Draw one sample's inputs and note what the next publish must show
    task automatic apply(input int i);
        exp_t e;
        int av, bv, amp, hi, lo, c;
        logic [31:0] sq;
        logic [7:0] p;
        seed = xs(seed);
        field_x = seed[15:0];
        field_y = seed[31:16];
        seed = xs(seed);
        field_z = seed[15:0];
        temp_raw = seed[31:16];
        seed = xs(seed);
        corrected_src_a = seed[15:0];
        corrected_src_b = seed[31:16];
        seed = xs(seed);
        position_src = seed[15:0];
        code_src = seed[31:16];
        seed = xs(seed);
        clamp_high_level = seed[15:0] | 16'h4000;
        clamp_low_level = seed[31:16] & 16'h3FFF;
        seed = xs(seed);
        p = seed[7:0];
        offset_select_a = seed[31:16] & 16'h7FFE;
        offset_select_b = seed[23:8] & 16'h7FFE;
        case (i % 4)
            0: {offset_select_a, offset_select_b} = {OFFSET_SEL_OFF, OFFSET_SEL_OFF};
            1: {offset_select_a, offset_select_b} = {OFFSET_SEL_ON, OFFSET_SEL_OFF};
            2: {offset_select_a, offset_select_b} = {OFFSET_SEL_OFF, OFFSET_SEL_ON};
            default: ;
        endcase
        field_high_threshold = 16'h7FFF;
        field_low_threshold = 16'h0000;
        if (i % 3 == 0) field_high_threshold = (i % 6 == 0) ? 16'h8000 : seed[15:0] & 16'h0FFF;
        if (i % 3 == 1 && i > 1) field_low_threshold = 16'h7FFF;
        if (i == 1) {corrected_src_a, corrected_src_b} = {16'h8000, 16'h8000};
        if (i == 2) p = 8'hFF;
        if (i % 5 == 4) clamp_high_level = 16'hFFFF;
        mon_pattern = p;
        e.temp = temp_raw[15] ? 16'h7FFF : temp_raw;
        e.pos = position_src[15] ? 16'h7FFF : position_src;
        e.fa = field_x;
        e.fb = field_z;
        e.ia = corrected_src_a;
        e.ib = corrected_src_b;
        av = int'(corrected_src_a);
        bv = int'(corrected_src_b);
        if (av < 0) av = -av;
        if (bv < 0) bv = -bv;
        if (offset_select_a == OFFSET_SEL_ON || offset_select_b == OFFSET_SEL_ON) begin
            amp = av + bv;
        end else begin
            sq = 32'(av * av) + 32'(bv * bv);
            amp = int'(isqrt(sq)) * 205 / 128;
        end
        if (amp > 32767) amp = 32767;
        hi = clamp_high_level[15] ? 32767 : int'(clamp_high_level);
        lo = int'(clamp_low_level);
        c = code_src[15] ? 32767 : int'(code_src);
        e.force_hi = amp > int'(field_high_threshold) || amp < int'(field_low_threshold);
        if (e.force_hi) c = hi;
        if (c > hi) c = hi;
        if (c < lo) c = lo;
        e.code = 16'(c);
        e.amp = 16'(amp);
        e.flags = {3'b000, p[7:6], 1'b0, c >= hi, c <= lo, p[5:0],
            amp > int'(field_high_threshold), amp < int'(field_low_threshold)};
        q.push_back(e);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < NV; i++) begin
            #1 apply(i);
            repeat (SC) @(posedge core_clk);
        end
    end

    // Watches each publish against the oldest note, and the cycle before it against the previous one
    initial begin
        exp_t e, p;
        wait (!rst);
        // Publish lands on edge SC + 18 after release; look one cycle earlier
        repeat (SC + 17) @(posedge core_clk);
        #2 check(field_amplitude | fault_flags | output_code, 16'h0000, "before first");
        for (int k = 0; k < NV; k++) begin
            if (k > 0) begin
                repeat (SC - 1) @(posedge core_clk);
                #2 check(output_code, p.code, "held code");
                check(fault_flags, p.flags, "held flags");
            end
            @(posedge core_clk);
            #2 e = q.pop_front();
            check(junction_temperature, e.temp, "temperature");
            check(compensated_field_a, e.fa, "field a");
            check(compensated_field_b, e.fb, "field b");
            check(corrected_input_a, e.ia, "input a");
            check(corrected_input_b, e.ib, "input b");
            check(position_result, e.pos, "position");
            check(output_code, e.code, "code");
            check(field_amplitude, e.amp, "amplitude");
            check(fault_flags, e.flags, "flags");
            check({15'h0000, force_high_clamp}, {15'h0000, e.force_hi}, "force");
            p = e;
        end
        complete_run;
    end

    initial begin
        #(NV * SC * 10 + 5000);
        fails++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run;
    end
endmodule // position_sensor_readout_diag_bench
